// ---- logic/ubrc_top.sv ----
// async serial block: mode, baud generator, transmitter and receiver
//
// Summary of operation
// - mode rewrite during send blocks later sends
// - send end raises pulse and sticky flag
// - reset empties sender with no done pulse
// - a data write starts a send only when idle, transmitter enabled and not locked
// - unread buffer on arrival flags overrun, persists
// - early read after error raises done anyway
// - buffer read clears errors; next character rewrites them
// - control write restarts divide counter and halver
// - internal rate is fxx/((k+16)*2^(n+3))
// - ext clock rate is fasck/2^(n+6), k zero
`timescale 1ns/1ps
`include "ubrc_regs.svh"

module ubrc_top (
  // clock and reset
  input  wire logic       clk_sys,
  input  wire logic       reset,
  // register writes and reads
  input  wire logic       wr_mode,            // write async_mode_reg
  input  wire logic       wr_baud,            // write baud_gen_ctrl
  input  wire logic       wr_tx,              // write tx_shift_reg
  input  wire logic [7:0] wdata,              // data for any write
  input  wire logic       rd_rx_buffer,       // read strobe of rx_buffer
  input  wire logic       clr_tx_done_flag,   // software clear
  input  wire logic       rx_irq_enable,      // reception interrupt enable
  // register contents and status
  output logic      [7:0] async_mode_reg,
  output logic      [7:0] baud_gen_ctrl,
  output logic      [7:0] rx_buffer,
  output logic      [1:0] rx_error_status,
  output logic            rx_full,            // buffer holds unread data
  output logic            tx_busy,
  output logic            tx_locked,          // sends blocked until reset
  // events
  output logic            tx_done_irq,
  output logic            tx_done_flag,
  output logic            rx_done_irq,
  output logic            rx_err_irq,
  // pins
  input  wire logic       ext_baud_clock_in,
  input  wire logic       rxd,
  output logic            txd
);

  // ----------------------------------------------------------------------
  // pin synchronisers
  // ----------------------------------------------------------------------
  logic [2:0] ext_sync;                       // [0] is metastable stage
  logic [2:0] rxd_sync;                       // [0] is metastable stage

  // third stage feeds the edge detectors and the receiver bit samples
  always_ff @(posedge clk_sys or posedge reset) begin
    if (reset) begin
      ext_sync <= 3'h0;
      rxd_sync <= 3'h7;
    end else begin
      ext_sync <= {ext_sync[1:0], ext_baud_clock_in};
      rxd_sync <= {rxd_sync[1:0], rxd};
    end
  end

  // ----------------------------------------------------------------------
  // control registers
  // ----------------------------------------------------------------------
  logic tx_en;                                // transmitter enabled
  logic rx_en;                                // receiver enabled

  assign tx_en = async_mode_reg[`UBRC_MODE_TXE_BIT];
  assign rx_en = async_mode_reg[`UBRC_MODE_RXE_BIT];

  // plain writes; nibble split is fixed by the generator wiring
  always_ff @(posedge clk_sys or posedge reset) begin
    if (reset) begin
      async_mode_reg <= `UBRC_MODE_RESET;
      baud_gen_ctrl  <= `UBRC_BRG_RESET;
    end else begin
      if (wr_mode)
        async_mode_reg <= wdata;
      if (wr_baud)
        baud_gen_ctrl <= wdata;
    end
  end

  // ----------------------------------------------------------------------
  // baud generator
  // ----------------------------------------------------------------------
  logic prs_tick;                             // reference clock
  logic half_tick;                            // half bit time
  logic bit_tick;                             // full bit time

  ubrc_baud_gen u_baud (
    .clk_sys      (clk_sys),
    .reset        (reset),
    .run          (tx_en | rx_en),
    .use_internal (async_mode_reg[`UBRC_MODE_SRC_BIT]),
    .ext_edge     (ext_sync[2] ^ ext_sync[1]),
    .ctrl_wr      (wr_baud),
    .tap          (baud_gen_ctrl[`UBRC_TAP_MSB:`UBRC_TAP_LSB]),
    .div          (baud_gen_ctrl[`UBRC_DIV_MSB:`UBRC_DIV_LSB]),
    .prs_tick     (prs_tick),
    .half_tick    (half_tick),
    .bit_tick     (bit_tick)
  );

  // ----------------------------------------------------------------------
  // transmitter
  // ----------------------------------------------------------------------
  ubrc_pkg::ubrc_tx_state_t tx_state;         // send sequence
  logic [7:0]               tx_shift_reg;     // outgoing byte
  logic [2:0]               tx_bit;           // data bit index
  logic                     tx_go;            // write accepted

  // writes while busy are dropped; the byte in flight is never torn
  assign tx_go = wr_tx && tx_en && !tx_locked &&
                 (tx_state == ubrc_pkg::UBRC_TX_IDLE);

  // start bit waits for the next bit tick, so latency is up to one bit
  always_ff @(posedge clk_sys or posedge reset) begin
    if (reset) begin
      tx_state     <= ubrc_pkg::UBRC_TX_IDLE;
      tx_shift_reg <= 8'h00;
      tx_bit       <= 3'h0;
      txd          <= 1'b1;
      tx_done_irq  <= 1'b0;
      tx_busy      <= 1'b0;
    end else begin
      tx_done_irq <= 1'b0;
      case (tx_state)
        ubrc_pkg::UBRC_TX_IDLE: begin
          if (tx_go) begin
            tx_shift_reg <= wdata;
            tx_state     <= ubrc_pkg::UBRC_TX_START;
            tx_busy      <= 1'b1;
          end
        end
        ubrc_pkg::UBRC_TX_START: begin
          if (bit_tick) begin
            txd      <= 1'b0;
            tx_bit   <= 3'h0;
            tx_state <= ubrc_pkg::UBRC_TX_DATA;
          end
        end
        ubrc_pkg::UBRC_TX_DATA: begin
          if (bit_tick) begin
            txd          <= tx_shift_reg[0];
            tx_shift_reg <= {1'b0, tx_shift_reg[7:1]};
            tx_bit       <= tx_bit + 3'h1;
            if (tx_bit == `UBRC_LAST_BIT)
              tx_state <= ubrc_pkg::UBRC_TX_STOP;
          end
        end
        ubrc_pkg::UBRC_TX_STOP: begin
          // tx_bit has wrapped to zero: stop bit gets a full bit time
          if (bit_tick && tx_bit == 3'h0) begin
            txd    <= 1'b1;                                  // stop bit out
            tx_bit <= 3'h1;
          end else if (bit_tick) begin
            tx_state    <= ubrc_pkg::UBRC_TX_IDLE;
            tx_busy     <= 1'b0;
            tx_done_irq <= 1'b1;
          end
        end
        default: begin
          tx_state <= ubrc_pkg::UBRC_TX_IDLE;
          txd      <= 1'b1;
        end
      endcase
    end
  end

  // sticky done flag; a new completion beats a clear in the same cycle
  always_ff @(posedge clk_sys or posedge reset) begin
    if (reset)
      tx_done_flag <= 1'b0;
    else if (tx_done_irq)
      tx_done_flag <= 1'b1;
    else if (clr_tx_done_flag)
      tx_done_flag <= 1'b0;
  end

  // mode rewrite mid send wedges the sender; only reset recovers
  always_ff @(posedge clk_sys or posedge reset) begin
    if (reset)
      tx_locked <= 1'b0;
    else if (wr_mode && tx_busy)
      tx_locked <= 1'b1;
  end

  // ----------------------------------------------------------------------
  // receiver
  // ----------------------------------------------------------------------
  ubrc_pkg::ubrc_rx_state_t rx_state;         // receive sequence
  logic [7:0]               rx_shift;         // incoming byte
  logic [2:0]               rx_bit;           // data bit index
  logic                     rx_phase;         // second half of bit
  logic                     rx_evt;           // character complete
  logic                     rx_frm;           // stop bit was low
  logic                     rx_sample;        // mid bit sample point

  assign rx_sample = half_tick && rx_phase;

  // start edge is resolved to one half-bit tick of jitter
  always_ff @(posedge clk_sys or posedge reset) begin
    if (reset) begin
      rx_state <= ubrc_pkg::UBRC_RX_IDLE;
      rx_shift <= 8'h00;
      rx_bit   <= 3'h0;
      rx_phase <= 1'b0;
      rx_evt   <= 1'b0;
      rx_frm   <= 1'b0;
    end else begin
      rx_evt <= 1'b0;
      if (half_tick)
        rx_phase <= ~rx_phase;
      case (rx_state)
        ubrc_pkg::UBRC_RX_IDLE: begin
          if (rx_en && rxd_sync[2] && !rxd_sync[1])
            rx_state <= ubrc_pkg::UBRC_RX_START;
        end
        ubrc_pkg::UBRC_RX_START: begin
          if (half_tick) begin
            rx_phase <= 1'b0;                 // next sample one bit on
            rx_bit   <= 3'h0;
            rx_state <= rxd_sync[2] ? ubrc_pkg::UBRC_RX_IDLE
                                    : ubrc_pkg::UBRC_RX_DATA;
          end
        end
        ubrc_pkg::UBRC_RX_DATA: begin
          if (rx_sample) begin
            rx_shift <= {rxd_sync[2], rx_shift[7:1]};
            rx_bit   <= rx_bit + 3'h1;
            if (rx_bit == `UBRC_LAST_BIT)
              rx_state <= ubrc_pkg::UBRC_RX_STOP;
          end
        end
        ubrc_pkg::UBRC_RX_STOP: begin
          if (rx_sample) begin
            rx_frm   <= !rxd_sync[2];
            rx_evt   <= 1'b1;
            rx_state <= ubrc_pkg::UBRC_RX_IDLE;
          end
        end
        default: rx_state <= ubrc_pkg::UBRC_RX_IDLE;
      endcase
    end
  end

  // buffer, error status and the early-read interrupt leak
  logic [1:0] err_age;                        // reference clocks since error

  always_ff @(posedge clk_sys or posedge reset) begin
    if (reset) begin
      rx_buffer       <= 8'h00;
      rx_full         <= 1'b0;
      rx_error_status <= `UBRC_ERR_RESET;
      rx_done_irq     <= 1'b0;
      rx_err_irq      <= 1'b0;
      err_age         <= 2'h0;
    end else begin
      rx_done_irq <= 1'b0;
      rx_err_irq  <= 1'b0;
      if (prs_tick && err_age != `UBRC_ERR_WAIT)
        err_age <= err_age + 2'h1;
      if (rx_evt) begin
        // arrival wins over a read in the same cycle
        rx_buffer <= rx_shift;
        rx_full   <= 1'b1;
        rx_error_status[`UBRC_ERR_FRM] <= rx_frm;
        rx_error_status[`UBRC_ERR_OVR] <= rx_full &&
          !rd_rx_buffer;
        err_age <= 2'h0;
        if (rx_frm || (rx_full && !rd_rx_buffer))
          rx_err_irq <= 1'b1;
        else
          rx_done_irq <= rx_irq_enable;
      end else if (rd_rx_buffer) begin
        rx_full         <= 1'b0;
        rx_error_status <= `UBRC_ERR_RESET;
        // read too soon after an error leaks a done interrupt
        if (rx_error_status != `UBRC_ERR_RESET &&
            err_age != `UBRC_ERR_WAIT)
          rx_done_irq <= 1'b1;
      end
    end
  end

  // ----------------------------------------------------------------------
  // checks
  // ----------------------------------------------------------------------
  sequence sq_tx_end;
    (tx_state == ubrc_pkg::UBRC_TX_STOP) && bit_tick && (tx_bit != 3'h0);
  endsequence

  sequence sq_overrun;
    rx_evt && rx_full && !rd_rx_buffer;
  endsequence

  AST_TX_DONE: assert property (@(posedge clk_sys) disable iff (reset)
    sq_tx_end |=> tx_done_irq ##1 tx_done_flag)
    else $error("send end gave no pulse or flag");

  AST_RESET_QUIET: assert property (@(posedge clk_sys)
    reset |=> !tx_done_irq && txd && !tx_busy)
    else $error("sender not empty and quiet after reset");

  AST_TX_START: assert property (@(posedge clk_sys) disable iff (reset)
    tx_go |=> tx_busy && (tx_state == ubrc_pkg::UBRC_TX_START))
    else $error("data write did not start a send");

  AST_TX_LOCK: assert property (
    @(posedge clk_sys) disable iff (reset)
    (wr_mode && tx_busy) |=> tx_locked)
    else $error("mode rewrite mid send not latched");

  AST_TX_LOCKED_IDLE: assert property (
    @(posedge clk_sys) disable iff (reset)
    (tx_locked && wr_tx && !tx_busy) |=> !tx_busy)
    else $error("locked sender accepted a write");

  AST_OVERRUN: assert property (@(posedge clk_sys) disable iff (reset)
    sq_overrun |=> rx_error_status[`UBRC_ERR_OVR] && rx_err_irq)
    else $error("overrun not flagged");

  AST_ERR_CLEAR: assert property (@(posedge clk_sys) disable iff (reset)
    (rd_rx_buffer && !rx_evt) |=> (rx_error_status == 2'h0) && !rx_full)
    else $error("buffer read left error status set");

  AST_EARLY_READ: assert property (@(posedge clk_sys) disable iff (reset)
    (rd_rx_buffer && !rx_evt && rx_error_status != 2'h0 && err_age < 2'h2)
      |=> rx_done_irq)
    else $error("early read after error gave no interrupt");

  AST_LATE_READ: assert property (@(posedge clk_sys) disable iff (reset)
    (rd_rx_buffer && !rx_evt && err_age == 2'h2 && !rx_irq_enable)
      |=> !rx_done_irq)
    else $error("late read raised a suppressed interrupt");

endmodule

// ---- logic/ubrc_regs.svh ----
// bit positions, reset values and divider constants of the async serial block
`ifndef UBRC_REGS_SVH
`define UBRC_REGS_SVH

// ----------------------------------------------------------------------
// mode register fields
// ----------------------------------------------------------------------
`define UBRC_MODE_SRC_BIT   0        // 1: internal generator, 0: ext clock
`define UBRC_MODE_RXE_BIT   6        // receiver enable
`define UBRC_MODE_TXE_BIT   7        // transmitter enable
`define UBRC_MODE_RESET     8'h00

// ----------------------------------------------------------------------
// baud generator control fields
// ----------------------------------------------------------------------
`define UBRC_TAP_MSB        7        // prescaler tap n
`define UBRC_TAP_LSB        4
`define UBRC_DIV_MSB        3        // counter divisor k
`define UBRC_DIV_LSB        0
`define UBRC_BRG_RESET      8'h00
`define UBRC_TAP_BASE       4'h2     // prescaler divides input by 2^(n+2)
`define UBRC_DIV_LAST_BASE  5'h0F    // 5-bit counter wraps after k+16 counts

// ----------------------------------------------------------------------
// error status fields
// ----------------------------------------------------------------------
`define UBRC_ERR_FRM        0        // framing error
`define UBRC_ERR_OVR        1        // overrun error
`define UBRC_ERR_RESET      2'h0

// ----------------------------------------------------------------------
// misc
// ----------------------------------------------------------------------
`define UBRC_LAST_BIT       3'h7     // eighth data bit index
`define UBRC_ERR_WAIT       2'h2     // reference clocks to hold off a read

`endif

// ---- logic/ubrc_pkg.sv ----
// types shared by the async serial block
package ubrc_pkg;

  // transmitter sequence
  typedef enum logic [1:0] {
    UBRC_TX_IDLE  = 2'b00,
    UBRC_TX_START = 2'b01,
    UBRC_TX_DATA  = 2'b10,
    UBRC_TX_STOP  = 2'b11
  } ubrc_tx_state_t;

  // receiver sequence
  typedef enum logic [1:0] {
    UBRC_RX_IDLE  = 2'b00,
    UBRC_RX_START = 2'b01,
    UBRC_RX_DATA  = 2'b10,
    UBRC_RX_STOP  = 2'b11
  } ubrc_rx_state_t;

endpackage

// ---- logic/ubrc_baud_gen.sv ----
// prescaler, 5-bit divide counter and divide-by-two stage
`timescale 1ns/1ps
`include "ubrc_regs.svh"

module ubrc_baud_gen #(
  parameter int PRS_W = 14                // prescaler counter width
) (
  // clock and reset
  input  wire logic       clk_sys,
  input  wire logic       reset,
  // control
  input  wire logic       run,            // tx or rx enabled
  input  wire logic       use_internal,   // source select
  input  wire logic       ext_edge,       // either edge of ext clock
  input  wire logic       ctrl_wr,        // control register written
  input  wire logic [3:0] tap,            // prescaler tap n
  input  wire logic [3:0] div,            // counter divisor k
  // ticks
  output logic            prs_tick,       // reference clock
  output logic            half_tick,      // half bit
  output logic            bit_tick        // full bit
);

  // ----------------------------------------------------------------------
  // state
  // ----------------------------------------------------------------------
  logic [PRS_W-1:0] prs_cnt;              // free prescaler
  logic [4:0]       div_cnt;              // 5-bit counter
  logic             div2;                 // divide-by-two stage
  logic             prs_in;               // prescaler input event
  logic             prs_hit;              // prescaler tap reached

  // mask of the low n+2 bits of the prescaler
  function automatic logic [PRS_W-1:0] tap_mask(input logic [3:0] n);
    logic [PRS_W:0] one_hot;
    one_hot  = '0;
    one_hot[n + `UBRC_TAP_BASE] = 1'b1;
    tap_mask = PRS_W'(one_hot - 1'b1);
  endfunction

  // both ext edges count, so ext mode yields fasck/2^(n+1) like the table
  assign prs_in  = use_internal | ext_edge;
  assign prs_hit = prs_in && ((prs_cnt & tap_mask(tap)) == tap_mask(tap));

  // prescaler: one input event per clk in internal mode
  always_ff @(posedge clk_sys or posedge reset) begin
    if (reset) begin
      prs_cnt  <= '0;
      prs_tick <= 1'b0;
    end else if (!run) begin
      prs_cnt  <= '0;
      prs_tick <= 1'b0;
    end else begin
      if (prs_in)
        prs_cnt <= prs_cnt + 1'b1;
      prs_tick <= prs_hit;
    end
  end

  // divide counter k+16 and halver; a control write restarts both
  always_ff @(posedge clk_sys or posedge reset) begin
    if (reset) begin
      div_cnt   <= 5'h00;
      div2      <= 1'b0;
      half_tick <= 1'b0;
      bit_tick  <= 1'b0;
    end else if (!run || ctrl_wr) begin
      div_cnt   <= 5'h00;
      div2      <= 1'b0;
      half_tick <= 1'b0;
      bit_tick  <= 1'b0;
    end else begin
      half_tick <= 1'b0;
      bit_tick  <= 1'b0;
      if (prs_tick) begin
        if (div_cnt == ({1'b0, div} + `UBRC_DIV_LAST_BASE)) begin
          div_cnt   <= 5'h00;
          half_tick <= 1'b1;
          div2      <= ~div2;
          bit_tick  <= div2;
        end else begin
          div_cnt <= div_cnt + 5'h01;
        end
      end
    end
  end

  // ----------------------------------------------------------------------
  // checks
  // ----------------------------------------------------------------------
  sequence sq_wrap;
    prs_tick && run && !ctrl_wr &&
      (div_cnt == ({1'b0, div} + `UBRC_DIV_LAST_BASE));
  endsequence

  AST_BRG_RESTART: assert property (@(posedge clk_sys) disable iff (reset)
    ctrl_wr |=> (div_cnt == 5'h00) && !div2 && !half_tick)
    else $error("divider not restarted by control write");

  AST_HALF_AFTER_WRAP: assert property (@(posedge clk_sys) disable iff (reset)
    sq_wrap |=> half_tick && (div_cnt == 5'h00))
    else $error("half tick missing after counter wrap");

endmodule

// ---- tb/ubrc_peer.sv ----
// remote serial peer: sends and hears 8N1 frames on the line
`timescale 1ns/1ps

module ubrc_peer (
  // serial lines
  input  wire logic txd,
  output logic      rxd
);
  int         bit_ns = 640;  // bit time, set by bench per rate
  logic [7:0] got;           // last byte heard
  logic       got_stop;      // stop level heard

  initial rxd = 1'b1;        // idle high

  // one frame; a low stop level makes a framing fault on purpose
  task automatic send(input logic [7:0] d, input logic stp);
    rxd = 1'b0;
    #(bit_ns);
    for (int i = 0; i < 8; i++) begin
      rxd = d[i];            // lsb first
      #(bit_ns);
    end
    rxd = stp;
    #(bit_ns);
    rxd = 1'b1;              // back to idle high
  endtask

  // sample in mid bit, timed from the start edge
  always begin
    @(negedge txd);
    #(bit_ns / 2);
    for (int i = 0; i < 8; i++) begin
      #(bit_ns);
      got[i] = txd;
    end
    #(bit_ns);
    got_stop = txd;
  end
endmodule

// ---- tb/test_uart_baud_and_rx_tx_control.sv ----
// self-checking bench for the async serial block
`timescale 1ns/1ps

module test_uart_baud_and_rx_tx_control;
  // ------------------------------------------------------------
  // signals
  // ------------------------------------------------------------
  logic       clk_sys = 1'b0;
  logic       reset = 1'b1;
  logic       wr_mode = 1'b0;
  logic       wr_baud = 1'b0;
  logic       wr_tx = 1'b0;
  logic [7:0] wdata = 8'h00;
  logic       rd_rx_buffer = 1'b0;
  logic       clr_tx_done_flag = 1'b0;
  logic       rx_irq_enable = 1'b0;
  logic       ext_baud_clock_in = 1'b0;
  logic       ext_on = 1'b0;   // gates the external baud clock
  logic [7:0] async_mode_reg, baud_gen_ctrl, rx_buffer;
  logic [1:0] rx_error_status;
  logic       rx_full, tx_busy, tx_locked, txd, rxd;
  logic       tx_done_irq, tx_done_flag, rx_done_irq, rx_err_irq;
  int         errors = 0;
  int         checks = 0;
  int         n_txd = 0;       // pulse counters
  int         n_rxd = 0;
  int         n_rxe = 0;
  int         k, n, e;
  logic [7:0] cfg [3] = '{8'h00, 8'h11, 8'h0E};

  always #2.5 clk_sys = ~clk_sys;
  always #20 if (ext_on) ext_baud_clock_in = ~ext_baud_clock_in;

  // count one-cycle event pulses so none is missed
  // idle in reset, so unknown outputs before the first edge never count
  always @(posedge clk_sys) begin
    if (!reset) begin
      n_txd <= n_txd + tx_done_irq;
      n_rxd <= n_rxd + rx_done_irq;
      n_rxe <= n_rxe + rx_err_irq;
    end
  end

  ubrc_top i_dut (.clk_sys(clk_sys), .reset(reset), .wr_mode(wr_mode),
    .wr_baud(wr_baud), .wr_tx(wr_tx), .wdata(wdata),
    .rd_rx_buffer(rd_rx_buffer), .clr_tx_done_flag(clr_tx_done_flag),
    .rx_irq_enable(rx_irq_enable), .async_mode_reg(async_mode_reg),
    .baud_gen_ctrl(baud_gen_ctrl), .rx_buffer(rx_buffer),
    .rx_error_status(rx_error_status), .rx_full(rx_full),
    .tx_busy(tx_busy), .tx_locked(tx_locked), .tx_done_irq(tx_done_irq),
    .tx_done_flag(tx_done_flag), .rx_done_irq(rx_done_irq),
    .rx_err_irq(rx_err_irq), .ext_baud_clock_in(ext_baud_clock_in),
    .rxd(rxd), .txd(txd));

  ubrc_peer i_peer (.txd(txd), .rxd(rxd));

  // ------------------------------------------------------------
  // tasks
  // ------------------------------------------------------------
  task automatic end_sim();
    $display("checks %0d errors %0d", checks, errors);
    if (errors == 0 && checks > 0)
      $display("verification passed");
    else
      $display("verification failed");
    $finish;
  endtask

  task automatic check(input logic [15:0] seen, input logic [15:0] exp);
    checks++;
    if (seen !== exp) begin
      errors++;
      $display("mismatch at %0t: saw %h want %h", $time, seen, exp);
    end
  endtask

  // reset held for ten cycles, released at a falling edge
  task automatic do_reset();
    reset = 1'b1;
    repeat (10) @(negedge clk_sys);
    reset = 1'b0;
  endtask

  // one-cycle write strobe: 0 mode, 1 baud, else tx data
  task automatic wr(input int sel, input logic [7:0] d);
    @(negedge clk_sys);
    wdata = d;
    case (sel)
      0: wr_mode = 1'b1;
      1: wr_baud = 1'b1;
      default: wr_tx = 1'b1;
    endcase
    @(negedge clk_sys);
    {wr_mode, wr_baud, wr_tx} = 3'b000;
  endtask

  // read strobe, called at a falling edge
  task automatic rd();
    rd_rx_buffer = 1'b1;
    @(negedge clk_sys);
    rd_rx_buffer = 1'b0;
  endtask

  // bounded wait: 0 txd, 1 tx_busy, else rx_err_irq reaches lvl
  task automatic wait_lvl(input int sel, input logic lvl, output int c);
    c = 0;
    while ((sel == 0 ? txd : sel == 1 ? tx_busy : rx_err_irq) !== lvl) begin
      @(negedge clk_sys);
      c++;
      if (c > 6000) begin
        errors++;
        $display("mismatch at %0t: wait timed out", $time);
        end_sim();
      end
    end
  endtask

  // send a byte with lsb 1, so the low run is the start bit alone
  task automatic tx(input logic [7:0] d, input int bit_clk);
    int c;
    int k0;
    k0 = n_txd;
    wr(2, d);
    check(tx_busy, 1'b1);
    wait_lvl(0, 1'b0, c);
    wait_lvl(0, 1'b1, c);
    check(c, bit_clk);
    wait_lvl(1, 1'b0, c);
    @(negedge clk_sys);
    check(n_txd - k0, 1);
    check(tx_done_flag, 1'b1);
    check(i_peer.got, d);
    check(i_peer.got_stop, 1'b1);
  endtask

  // ------------------------------------------------------------
  // main sequence
  // ------------------------------------------------------------
  initial begin
    do_reset();
    check({async_mode_reg, baud_gen_ctrl}, 16'h0000);
    check({txd, tx_busy, tx_done_flag, n_txd[0]}, 4'h8);
    $display("test reset done");
    wr(1, 8'hB4);
    check(baud_gen_ctrl, 8'hB4);
    wr(0, 8'hC1);
    check(async_mode_reg, 8'hC1);
    // internal rates, divisors k=0, 1 and 14; taps kept legal
    foreach (cfg[i]) begin
      wr(1, cfg[i]);
      e = (int'(cfg[i][3:0]) + 16) * (2 ** (int'(cfg[i][7:4]) + 3));
      i_peer.bit_ns = e * 5;
      tx(8'hA5 ^ (cfg[i] & 8'hFE), e);
    end
    clr_tx_done_flag = 1'b1;
    @(negedge clk_sys);
    clr_tx_done_flag = 1'b0;
    check(tx_done_flag, 1'b0);
    $display("test transmit done");
    wr(1, 8'h00);
    i_peer.bit_ns = 640;
    rx_irq_enable = 1'b1;
    k = n_rxd;
    i_peer.send(8'h3C, 1'b1);
    repeat (4) @(negedge clk_sys);
    check({rx_full, rx_error_status, rx_buffer}, 11'h43C);
    check(n_rxd - k, 1);
    rd();
    @(negedge clk_sys);
    check(rx_full, 1'b0);
    // unread buffer meets the next characters
    e = n_rxe;
    i_peer.send(8'h11, 1'b1);
    i_peer.send(8'h22, 1'b1);
    repeat (4) @(negedge clk_sys);
    check({rx_error_status, rx_buffer}, 10'h222);
    i_peer.send(8'h33, 1'b1);
    repeat (4) @(negedge clk_sys);
    check(rx_error_status, 2'h2);
    check(n_rxe - e, 2);
    rd();
    @(negedge clk_sys);
    check(rx_error_status, 2'h0);
    $display("test receive done");
    // framing fault with the interrupt off: early then late read
    rx_irq_enable = 1'b0;
    for (int late = 0; late < 2; late++) begin
      k = n_rxd;
      fork
        i_peer.send(8'h44, 1'b0);
      join_none
      wait_lvl(2, 1'b1, n);
      check(rx_error_status[0], 1'b1);
      if (late)
        repeat (20) @(negedge clk_sys);  // past two reference clocks
      rd();
      repeat (4) @(negedge clk_sys);
      check(n_rxd - k, 1 - late);
      check(rx_error_status, 2'h0);
      repeat (200) @(negedge clk_sys);
    end
    $display("test error read done");
    // external baud clock, divisor zero
    ext_on = 1'b1;
    wr(0, 8'hC0);
    wr(1, 8'h00);
    i_peer.bit_ns = 2560;
    tx(8'hA5, 512);
    ext_on = 1'b0;
    i_peer.bit_ns = 640;
    wr(0, 8'hC1);
    $display("test external clock done");
    // mode rewrite mid send locks the sender until reset
    wr(2, 8'hA5);
    repeat (20) @(negedge clk_sys);
    wr(0, 8'hC1);
    check(tx_locked, 1'b1);
    wait_lvl(1, 1'b0, n);
    @(negedge clk_sys);
    k = n_txd;
    wr(2, 8'h01);
    @(negedge clk_sys);
    check(tx_busy, 1'b0);
    do_reset();
    check({tx_locked, tx_done_flag, txd}, 3'h1);
    check(n_txd - k, 0);
    wr(0, 8'hC1);
    tx(8'h01, 128);
    $display("test lock done");
    end_sim();
  end
endmodule
